/* design/dcog_top.sv */
// Register bank for output 1 negative side and DAC sub-channels 1A and 1B.
// Assumes a byte-wide control port already decoded from the serial
// control interface, synchronous to ref_clk_in.
`timescale 1ns/1ps
`include "dcog_map.svh"
module dcog_top #(
	parameter int SMP_W = 24
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic reg_unmapped_out,
	output logic reg_rsvd_wr_out,
	// Operating context from the rest of the device
	input wire logic dac_chain_in,
	input wire logic dac_chain_se_in,
	input wire logic wide_bw_in,
	input wire logic vref_2p75_in,
	// Negative output configuration fields
	output logic [1:0] neg_output_drive_select_out,
	output logic [3:0] neg_drive_onehot_out,
	output logic [2:0] neg_output_level_select_out,
	output logic [5:0] neg_level_db_out,
	output logic bypass_input_impedance_sel_out,
	output logic ch1_fullscale_select_out,
	output logic ch1_common_mode_tolerance_out,
	// Configuration checks
	output logic level_reserved_out,
	output logic level_conflict_out,
	output logic fullscale_conflict_out,
	// Sub-channel gain fields
	output logic [7:0] ch1a_volume_out,
	output logic [3:0] ch1a_fine_gain_out,
	output logic [7:0] ch1b_volume_out,
	output logic [3:0] ch1b_fine_gain_out,
	// Sample path
	input wire logic signed [SMP_W-1:0] ch1a_smp_in,
	input wire logic signed [SMP_W-1:0] ch1b_smp_in,
	input wire logic smp_vld_in,
	output logic signed [SMP_W-1:0] ch1a_smp_out,
	output logic signed [SMP_W-1:0] ch1b_smp_out,
	output logic smp_vld_out
);
	localparam int NCH = 2;

	// Register state
	logic [7:0] neg_cfg_d, neg_cfg_q;
	logic [7:0] vol_d [NCH];
	logic [7:0] vol_q [NCH];
	logic [3:0] fine_d [NCH];
	logic [3:0] fine_q [NCH];

	// Read port state
	logic [7:0] rdata_d, rdata_q;
	logic rvalid_d, rvalid_q;
	logic unmapped_d, unmapped_q;
	logic rsvd_wr_d, rsvd_wr_q;

	// Decoded state
	logic [3:0] onehot_d, onehot_q;
	logic [5:0] level_db_d, level_db_q;
	logic lvl_rsvd_d, lvl_rsvd_q;
	logic lvl_conf_d, lvl_conf_q;
	logic fs_conf_d, fs_conf_q;

	// Address hits
	logic hit_neg, hit_vol_a, hit_fine_a, hit_vol_b, hit_fine_b;
	logic hit_any;
	logic [NCH-1:0] hit_vol, hit_fine;

	// Field views
	dcog_pkg::dcog_drive_e drive_f;
	dcog_pkg::dcog_level_e level_f;
	logic byp_f, fs_f, cm_f;

	// Sample arrays per sub-channel
	logic signed [SMP_W-1:0] smp_in_arr [NCH];
	logic signed [SMP_W-1:0] smp_out_arr [NCH];
	logic [NCH-1:0] smp_vld_arr;

	// Address decode
	always_comb begin
		hit_neg = (reg_addr_in == `DCOG_ADDR_NEG_CFG); // [R13]
		hit_vol_a = (reg_addr_in == `DCOG_ADDR_VOL_A); // [R14]
		hit_fine_a = (reg_addr_in == `DCOG_ADDR_FINE_A); // [R14]
		hit_vol_b = (reg_addr_in == `DCOG_ADDR_VOL_B); // [R9]
		hit_fine_b = (reg_addr_in == `DCOG_ADDR_FINE_B); // [R12]
		hit_vol = {hit_vol_b, hit_vol_a};
		hit_fine = {hit_fine_b, hit_fine_a};
		hit_any = hit_neg | hit_vol_a | hit_fine_a | hit_vol_b | hit_fine_b;
	end

	// Negative output configuration byte
	always_comb begin
		neg_cfg_d = neg_cfg_q;
		if (reg_wr_in && hit_neg) begin
			neg_cfg_d = reg_wdata_in; // [R16]
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			neg_cfg_q <= `DCOG_RST_NEG_CFG; // [R13] [R1] [R2] [R4]
		end else begin
			neg_cfg_q <= neg_cfg_d;
		end
	end

	// Per sub-channel volume and fine gain
	for (genvar ch = 0; ch < NCH; ch++) begin : g_sub
		dcog_gain_if #(.SMP_W(SMP_W)) gif ();

		always_comb begin
			vol_d[ch] = vol_q[ch];
			fine_d[ch] = fine_q[ch];
			if (reg_wr_in && hit_vol[ch]) begin
				vol_d[ch] = reg_wdata_in; // [R7] [R9] [R16]
			end
			if (reg_wr_in && hit_fine[ch]) begin
				fine_d[ch] = reg_wdata_in[`DCOG_FINE_MSB:`DCOG_FINE_LSB]; // [R10] [R15]
			end
		end

		always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				vol_q[ch] <= `DCOG_RST_VOL; // [R8] [R9]
				fine_q[ch] <= `DCOG_RST_FINE; // [R10] [R12] [R15]
			end else begin
				vol_q[ch] <= vol_d[ch];
				fine_q[ch] <= fine_d[ch];
			end
		end

		assign gif.vol = vol_q[ch];
		assign gif.fine = fine_q[ch];
		assign gif.smp_in = smp_in_arr[ch];
		assign gif.smp_in_vld = smp_vld_in;
		assign smp_out_arr[ch] = gif.smp_out;
		assign smp_vld_arr[ch] = gif.smp_out_vld;

		dcog_gain_stage #(
			.SMP_W(SMP_W)
		) u_stage (
			.clk_in(ref_clk_in),
			.arst_n_in(arst_n_in),
			.gif(gif)
		); // [R16]
	end

	// Read port and reserved write check
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		unmapped_d = 1'b0;
		rsvd_wr_d = 1'b0;
		if (reg_rd_in) begin
			rvalid_d = 1'b1;
			case (1'b1)
				hit_neg: begin
					rdata_d = neg_cfg_q; // [R16]
				end
				hit_vol_a: begin
					rdata_d = vol_q[0]; // [R16]
				end
				hit_fine_a: begin
					rdata_d = {fine_q[0], `DCOG_RSVD_VAL}; // [R11]
				end
				hit_vol_b: begin
					rdata_d = vol_q[1]; // [R16]
				end
				hit_fine_b: begin
					rdata_d = {fine_q[1], `DCOG_RSVD_VAL}; // [R11] [R15]
				end
				default: begin
					rdata_d = 8'h00;
					unmapped_d = 1'b1;
				end
			endcase
		end
		if (reg_wr_in && !hit_any) begin
			unmapped_d = 1'b1;
		end
		if (reg_wr_in && (hit_fine_a || hit_fine_b) &&
			(reg_wdata_in[`DCOG_RSVD_MSB:0] != `DCOG_RSVD_VAL)) begin
			rsvd_wr_d = 1'b1; // [R11]
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			unmapped_q <= 1'b0;
			rsvd_wr_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			unmapped_q <= unmapped_d;
			rsvd_wr_q <= rsvd_wr_d;
		end
	end

	// Field decode of the negative output byte
	always_comb begin
		drive_f = dcog_pkg::dcog_drive_e'(neg_cfg_q[`DCOG_DRIVE_MSB:`DCOG_DRIVE_LSB]);
		level_f = dcog_pkg::dcog_level_e'(neg_cfg_q[`DCOG_LVL_MSB:`DCOG_LVL_LSB]);
		byp_f = neg_cfg_q[`DCOG_BYP_BIT];
		fs_f = neg_cfg_q[`DCOG_FS_BIT];
		cm_f = neg_cfg_q[`DCOG_CM_BIT];
	end

	// Driver type one-hot
	always_comb begin
		case (drive_f)
			dcog_pkg::DCOG_DRV_LINE_OUT: begin
				onehot_d = 4'h1; // [R1]
			end
			dcog_pkg::DCOG_DRV_HEADPHONE: begin
				onehot_d = 4'h2; // [R1]
			end
			dcog_pkg::DCOG_DRV_4OHM: begin
				onehot_d = 4'h4; // [R1]
			end
			dcog_pkg::DCOG_DRV_RECEIVER: begin
				onehot_d = 4'h8; // [R1]
			end
			default: begin
				onehot_d = 4'h1;
			end
		endcase
	end

	// Level in dB and its legality
	always_comb begin
		lvl_rsvd_d = 1'b0;
		lvl_conf_d = 1'b0;
		case (level_f)
			dcog_pkg::DCOG_LVL_P24: begin
				level_db_d = 6'h18; // [R2]
				lvl_conf_d = !(dac_chain_in && dac_chain_se_in); // [R2]
			end
			dcog_pkg::DCOG_LVL_P18: begin
				level_db_d = 6'h12; // [R2]
				lvl_conf_d = !dac_chain_in; // [R2]
			end
			dcog_pkg::DCOG_LVL_P12: begin
				level_db_d = 6'h0C; // [R2]
			end
			dcog_pkg::DCOG_LVL_P6: begin
				level_db_d = 6'h06; // [R2]
			end
			dcog_pkg::DCOG_LVL_0: begin
				level_db_d = 6'h00; // [R2]
			end
			dcog_pkg::DCOG_LVL_M6: begin
				level_db_d = 6'h3A; // [R2]
			end
			dcog_pkg::DCOG_LVL_M12: begin
				level_db_d = 6'h34; // [R2]
				lvl_conf_d = byp_f; // [R3]
			end
			default: begin
				level_db_d = 6'h00;
				lvl_rsvd_d = 1'b1; // [R2]
			end
		endcase
		fs_conf_d = fs_f && (wide_bw_in || !vref_2p75_in); // [R5]
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			onehot_q <= 4'h1;
			level_db_q <= 6'h00;
			lvl_rsvd_q <= 1'b0;
			lvl_conf_q <= 1'b0;
			fs_conf_q <= 1'b0;
		end else begin
			onehot_q <= onehot_d;
			level_db_q <= level_db_d;
			lvl_rsvd_q <= lvl_rsvd_d;
			lvl_conf_q <= lvl_conf_d;
			fs_conf_q <= fs_conf_d;
		end
	end

	// Sample ports
	assign smp_in_arr[0] = ch1a_smp_in;
	assign smp_in_arr[1] = ch1b_smp_in;
	assign ch1a_smp_out = smp_out_arr[0];
	assign ch1b_smp_out = smp_out_arr[1];
	assign smp_vld_out = smp_vld_arr[0];

	// Register port outputs
	assign reg_rdata_out = rdata_q;
	assign reg_rvalid_out = rvalid_q;
	assign reg_unmapped_out = unmapped_q;
	assign reg_rsvd_wr_out = rsvd_wr_q;

	// Field outputs
	assign neg_output_drive_select_out = neg_cfg_q[`DCOG_DRIVE_MSB:`DCOG_DRIVE_LSB]; // [R1]
	assign neg_drive_onehot_out = onehot_q;
	assign neg_output_level_select_out = neg_cfg_q[`DCOG_LVL_MSB:`DCOG_LVL_LSB]; // [R2]
	assign neg_level_db_out = level_db_q;
	assign bypass_input_impedance_sel_out = byp_f; // [R4]
	assign ch1_fullscale_select_out = fs_f; // [R5]
	assign ch1_common_mode_tolerance_out = cm_f; // [R6]
	assign level_reserved_out = lvl_rsvd_q;
	assign level_conflict_out = lvl_conf_q;
	assign fullscale_conflict_out = fs_conf_q;
	assign ch1a_volume_out = vol_q[0];
	assign ch1a_fine_gain_out = fine_q[0];
	assign ch1b_volume_out = vol_q[1];
	assign ch1b_fine_gain_out = fine_q[1];
endmodule

/* design/dcog_map.svh */
// Offsets, field positions and reset values of the output 1 gain bank.
// Assumes byte-wide registers reached at their printed addresses.
// Contract
// R1: Drive select bits 7-6: line out, headphone, 4 ohm, receiver; reset 0.
// R2: Level select bits 5-3: 24 to -12 dB in 6 dB steps, 7 reserved.
// R3: The -12 dB level is valid only with the 4.4 kilohm input option.
// R4: Bit 2 picks bypass input impedance: 0 low option, 1 is 20 kilohm.
// R5: Bit 1 picks 2 or 4 Vrms full scale; 4 Vrms audio band only.
// R6: Bit 0 picks limited AC or rail-to-rail common-mode tolerance.
// R7: Volume code 0 mutes, 1 is -100 dB, 0.5 dB per code upward.
// R8: Volume of sub-channel 1A resets to the 0 dB code 0xC9.
// R9: Sub-channel 1B has its own volume byte, same coding and reset.
// R10: Fine gain bits 7-4: -0.8 to +0.7 dB in 0.1 dB; reset 8.
// R11: Fine gain bits 3-0 read zero; host writes only zero there.
// R12: Sub-channel 1B fine gain byte at 0x6A resets to 0x80.
// R13: Negative output byte sits at 0x66 and resets to 0x20.
// R14: 1A volume at 0x67 resets 0xC9; 1A fine gain 0x68 resets 0x80.
// R15: 1B fine gain byte has the same layout as that of 1A.
// R16: Writable fields read back as written; gains act on the samples.
`ifndef DCOG_MAP_SVH
`define DCOG_MAP_SVH

`define DCOG_ADDR_NEG_CFG 8'h66
`define DCOG_ADDR_VOL_A 8'h67
`define DCOG_ADDR_FINE_A 8'h68
`define DCOG_ADDR_VOL_B 8'h69
`define DCOG_ADDR_FINE_B 8'h6A

`define DCOG_RST_NEG_CFG 8'h20
`define DCOG_RST_VOL 8'hC9
`define DCOG_RST_FINE 4'h8
`define DCOG_RST_FINE_BYTE 8'h80
`define DCOG_RSVD_VAL 4'h0

`define DCOG_DRIVE_MSB 7
`define DCOG_DRIVE_LSB 6
`define DCOG_LVL_MSB 5
`define DCOG_LVL_LSB 3
`define DCOG_BYP_BIT 2
`define DCOG_FS_BIT 1
`define DCOG_CM_BIT 0
`define DCOG_FINE_MSB 7
`define DCOG_FINE_LSB 4
`define DCOG_RSVD_MSB 3

`endif

/* design/dcog_pkg.sv */
// Types shared by the output 1 gain bank modules.
// Assumes the map header supplies all numeric constants.
package dcog_pkg;

	typedef enum logic [1:0] {
		DCOG_DRV_LINE_OUT = 2'h0,
		DCOG_DRV_HEADPHONE = 2'h1,
		DCOG_DRV_4OHM = 2'h2,
		DCOG_DRV_RECEIVER = 2'h3
	} dcog_drive_e;

	typedef enum logic [2:0] {
		DCOG_LVL_P24 = 3'h0,
		DCOG_LVL_P18 = 3'h1,
		DCOG_LVL_P12 = 3'h2,
		DCOG_LVL_P6 = 3'h3,
		DCOG_LVL_0 = 3'h4,
		DCOG_LVL_M6 = 3'h5,
		DCOG_LVL_M12 = 3'h6,
		DCOG_LVL_RSVD = 3'h7
	} dcog_level_e;

	typedef logic signed [5:0] dcog_db_t;

endpackage

/* design/dcog_gain_if.sv */
// Carrier between the register bank and one sub-channel gain stage.
// Assumes both ends share the bank clock.
`timescale 1ns/1ps
interface dcog_gain_if #(
	parameter int SMP_W = 24
);
	logic [7:0] vol;
	logic [3:0] fine;
	logic signed [SMP_W-1:0] smp_in;
	logic smp_in_vld;
	logic signed [SMP_W-1:0] smp_out;
	logic smp_out_vld;

	modport ctrl(output vol, output fine, output smp_in, output smp_in_vld,
		input smp_out, input smp_out_vld);
	modport stage(input vol, input fine, input smp_in, input smp_in_vld,
		output smp_out, output smp_out_vld);
endinterface

/* design/dcog_gain_stage.sv */
// Applies digital volume and fine gain to one sub-channel's samples.
// Assumes samples arrive synchronous to the clock with a valid strobe.
`timescale 1ns/1ps
module dcog_gain_stage #(
	parameter int SMP_W = 24
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Gain settings and samples
	dcog_gain_if.stage gif
);
	localparam int PW = SMP_W + 44;

	logic signed [SMP_W-1:0] smp_d, smp_q;
	logic vld_d, vld_q;
	logic [8:0] n_idx;
	logic [4:0] oct;
	logic [3:0] mant_sel;
	logic signed [16:0] mant_g, fine_g;
	logic signed [PW-1:0] prod, shifted, maxv, minv;

	// Half-dB steps within one 6 dB span, Q2.14
	function automatic logic [15:0] mant_lut(input logic [3:0] k);
		case (k)
			4'h0: mant_lut = 16'h4000;
			4'h1: mant_lut = 16'h43CB;
			4'h2: mant_lut = 16'h47CF;
			4'h3: mant_lut = 16'h4C10;
			4'h4: mant_lut = 16'h5092;
			4'h5: mant_lut = 16'h5558;
			4'h6: mant_lut = 16'h5A67;
			4'h7: mant_lut = 16'h5FC2;
			4'h8: mant_lut = 16'h656F;
			4'h9: mant_lut = 16'h6B72;
			4'hA: mant_lut = 16'h71CF;
			4'hB: mant_lut = 16'h788E;
			default: mant_lut = 16'h4000;
		endcase
	endfunction

	// Fine gain -0.8 dB to +0.7 dB in 0.1 dB steps, Q2.14
	function automatic logic [15:0] fine_lut(input logic [3:0] k);
		case (k)
			4'h0: fine_lut = 16'h3A5F;
			4'h1: fine_lut = 16'h3B0B;
			4'h2: fine_lut = 16'h3BBC;
			4'h3: fine_lut = 16'h3C6C;
			4'h4: fine_lut = 16'h3D1F;
			4'h5: fine_lut = 16'h3DD5;
			4'h6: fine_lut = 16'h3E8B;
			4'h7: fine_lut = 16'h3F45;
			4'h8: fine_lut = 16'h4000;
			4'h9: fine_lut = 16'h40BE;
			4'hA: fine_lut = 16'h417E;
			4'hB: fine_lut = 16'h4240;
			4'hC: fine_lut = 16'h4304;
			4'hD: fine_lut = 16'h43CB;
			4'hE: fine_lut = 16'h4494;
			default: fine_lut = 16'h455F;
		endcase
	endfunction

	always_comb begin
		// Code 201 lands on a whole span so that 0 dB is exactly unity
		n_idx = {1'b0, gif.vol} + 9'h00F;
		oct = 5'(n_idx / 9'h00C);
		mant_sel = 4'(n_idx % 9'h00C);
		mant_g = {1'b0, mant_lut(mant_sel)};
		fine_g = {1'b0, fine_lut(gif.fine)}; // [R10]
		prod = PW'(gif.smp_in) * PW'(mant_g) * PW'(fine_g);
		if (oct > 5'h12) begin
			shifted = (prod <<< (oct - 5'h12)) >>> 28; // [R7]
		end else begin
			shifted = (prod >>> (5'h12 - oct)) >>> 28; // [R7]
		end
		maxv = PW'({1'b0, {(SMP_W-1){1'b1}}});
		minv = -maxv - PW'(1);
		if (gif.vol == 8'h00) begin
			smp_d = '0; // [R7]
		end else if (shifted > maxv) begin
			smp_d = maxv[SMP_W-1:0];
		end else if (shifted < minv) begin
			smp_d = minv[SMP_W-1:0];
		end else begin
			smp_d = shifted[SMP_W-1:0]; // [R16]
		end
		vld_d = gif.smp_in_vld;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			smp_q <= '0;
			vld_q <= 1'b0;
		end else begin
			smp_q <= gif.smp_in_vld ? smp_d : smp_q;
			vld_q <= vld_d;
		end
	end

	assign gif.smp_out = smp_q;
	assign gif.smp_out_vld = vld_q;
endmodule

/* verif/dcog_top_properties.sv */
// Concurrent checks on the ports of the output 1 gain bank.
// Assumes one clock domain and the byte strobe register port.
`timescale 1ns/1ps
module dcog_top_properties #(
	parameter int SMP_W = 24
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic reg_unmapped_out,
	// Fields and samples
	input wire logic [1:0] neg_output_drive_select_out,
	input wire logic [2:0] neg_output_level_select_out,
	input wire logic level_reserved_out,
	input wire logic [7:0] ch1a_volume_out,
	input wire logic [3:0] ch1a_fine_gain_out,
	input wire logic [7:0] ch1b_volume_out,
	input wire logic signed [SMP_W-1:0] ch1a_smp_in,
	input wire logic smp_vld_in,
	input wire logic signed [SMP_W-1:0] ch1a_smp_out,
	input wire logic signed [SMP_W-1:0] ch1b_smp_out,
	// Decoded fields, flags and context
	input wire logic reg_rsvd_wr_out,
	input wire logic [3:0] neg_drive_onehot_out,
	input wire logic bypass_input_impedance_sel_out,
	input wire logic ch1_fullscale_select_out,
	input wire logic level_conflict_out,
	input wire logic fullscale_conflict_out,
	input wire logic wide_bw_in,
	input wire logic [3:0] ch1b_fine_gain_out,
	input wire logic smp_vld_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered");
	chk_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
		else $error("answer without read");
	chk_vol_a_write: assert property ((reg_wr_in && reg_addr_in == 8'h67)
		|=> ch1a_volume_out == $past(reg_wdata_in)) else $error("1A volume not stored");
	chk_vol_b_write: assert property ((reg_wr_in && reg_addr_in == 8'h69)
		|=> ch1b_volume_out == $past(reg_wdata_in)) else $error("1B volume not stored");
	chk_fine_a_write: assert property ((reg_wr_in && reg_addr_in == 8'h68)
		|=> ch1a_fine_gain_out == 4'($past(reg_wdata_in) >> 4)) else $error("fine gain");
	chk_rsvd_reads_zero: assert property ((reg_rvalid_out &&
		($past(reg_addr_in) == 8'h68 || $past(reg_addr_in) == 8'h6A))
		|-> reg_rdata_out[3:0] == 4'h0) else $error("reserved bits not zero");
	chk_drive_level_write: assert property ((reg_wr_in && reg_addr_in == 8'h66)
		|=> {neg_output_drive_select_out, neg_output_level_select_out}
		== 5'($past(reg_wdata_in) >> 3)) else $error("drive or level not stored");
	chk_level_rsvd: assert property (neg_output_level_select_out == 3'h7
		|=> level_reserved_out) else $error("reserved level not flagged");
	chk_unity_gain: assert property ((smp_vld_in && ch1a_volume_out == 8'hC9
		&& ch1a_fine_gain_out == 4'h8) |=> ch1a_smp_out == $past(ch1a_smp_in))
		else $error("unity gain altered sample");
	chk_mute_b: assert property ((smp_vld_in && ch1b_volume_out == 8'h00)
		|=> ch1b_smp_out == '0) else $error("mute code passed signal");
	chk_unmapped_flag: assert property (((reg_wr_in || reg_rd_in) &&
		(reg_addr_in < 8'h66 || reg_addr_in > 8'h6A)) |=> reg_unmapped_out)
		else $error("unmapped access not flagged");
	chk_drive_onehot: assert property (neg_drive_onehot_out ==
		(4'h1 << $past(neg_output_drive_select_out))) else $error("drive one-hot wrong");
	chk_m12_conflict: assert property ((neg_output_level_select_out == 3'h6 &&
		bypass_input_impedance_sel_out) |=> level_conflict_out)
		else $error("-12 dB with 20 kilohm not flagged");
	chk_fs_conflict: assert property ((ch1_fullscale_select_out && wide_bw_in)
		|=> fullscale_conflict_out) else $error("4 Vrms in wide band not flagged");
	chk_rsvd_wr_flag: assert property ((reg_wr_in && reg_addr_in == 8'h6A &&
		reg_wdata_in[3:0] != 4'h0) |=> reg_rsvd_wr_out) else $error("reserved write missed");
	chk_fine_b_write: assert property ((reg_wr_in && reg_addr_in == 8'h6A)
		|=> ch1b_fine_gain_out == 4'($past(reg_wdata_in) >> 4)) else $error("1B fine gain");
	chk_sample_valid: assert property (smp_vld_in |=> smp_vld_out)
		else $error("sample valid not answered");
endmodule

bind dcog_top dcog_top_properties #(.SMP_W(SMP_W)) i_dcog_top_properties (
	.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.reg_unmapped_out(reg_unmapped_out),
	.neg_output_drive_select_out(neg_output_drive_select_out),
	.neg_output_level_select_out(neg_output_level_select_out),
	.level_reserved_out(level_reserved_out), .ch1a_volume_out(ch1a_volume_out),
	.ch1a_fine_gain_out(ch1a_fine_gain_out), .ch1b_volume_out(ch1b_volume_out),
	.ch1a_smp_in(ch1a_smp_in), .smp_vld_in(smp_vld_in), .ch1a_smp_out(ch1a_smp_out),
	.ch1b_smp_out(ch1b_smp_out), .reg_rsvd_wr_out(reg_rsvd_wr_out),
	.neg_drive_onehot_out(neg_drive_onehot_out),
	.bypass_input_impedance_sel_out(bypass_input_impedance_sel_out),
	.ch1_fullscale_select_out(ch1_fullscale_select_out),
	.level_conflict_out(level_conflict_out), .fullscale_conflict_out(fullscale_conflict_out),
	.wide_bw_in(wide_bw_in), .ch1b_fine_gain_out(ch1b_fine_gain_out),
	.smp_vld_out(smp_vld_out));

/* verif/dcog_host_model.sv */
// Host that writes and reads the gain bank over the byte strobe port.
// Assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
module dcog_host_model (
	// Clock
	input wire logic clk_in,
	// Register port requests
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// Fine gain low bits go out as zero unless raw asks otherwise
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic raw);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= (!raw && (a == 8'h68 || a == 8'h6A)) ? {d[7:4], 4'h0} : d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
	endtask
endmodule

/* verif/dcog_top_test.sv */
// Self-checking bench for the output 1 gain bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module dcog_top_test;
	localparam int W = 24;
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] addr, wdata, rdata, d, e, a;
	logic wr, rd, rvalid, vld_out;
	logic vld_in = 1'b0;
	logic [3:0] ctx = 4'h0;
	logic signed [W-1:0] a_in = '0, b_in = '0, a_out, b_out, x;
	logic [7:0] rq[$];
	logic [W-1:0] aq[$], bq[$];
	int error_cnt = 0, n_compared = 0, seed = 31890;

	always #2.5 ref_clk_in = ~ref_clk_in;

	dcog_host_model i_dcog_host_model (.clk_in(ref_clk_in), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	dcog_top #(.SMP_W(W)) i_dcog_top (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_unmapped_out(),
		.reg_rsvd_wr_out(), .dac_chain_in(ctx[0]), .dac_chain_se_in(ctx[1]),
		.wide_bw_in(ctx[2]), .vref_2p75_in(ctx[3]), .neg_output_drive_select_out(),
		.neg_drive_onehot_out(), .neg_output_level_select_out(), .neg_level_db_out(),
		.bypass_input_impedance_sel_out(), .ch1_fullscale_select_out(),
		.ch1_common_mode_tolerance_out(), .level_reserved_out(), .level_conflict_out(),
		.fullscale_conflict_out(), .ch1a_volume_out(), .ch1a_fine_gain_out(),
		.ch1b_volume_out(), .ch1b_fine_gain_out(), .ch1a_smp_in(a_in), .ch1b_smp_in(b_in),
		.smp_vld_in(vld_in), .ch1a_smp_out(a_out), .ch1b_smp_out(b_out),
		.smp_vld_out(vld_out));

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] ad, input logic [7:0] ex);
		rq.push_back(ex);
		i_dcog_host_model.rd(ad);
	endtask

	task automatic end_test(input string s);
		repeat (3) @(posedge ref_clk_in);
		$display("test %s done, mismatches %0d", s, error_cnt);
	endtask

	// Takes the oldest note whenever a result appears
	always @(posedge ref_clk_in) begin : mon
		logic [7:0] er;
		logic [W-1:0] ea, eb;
		if (rvalid === 1'b1) begin
			er = rq.size() ? rq.pop_front() : 8'hXX;
			`CHK(rdata, er)
		end
		if (vld_out === 1'b1) begin
			ea = aq.size() ? aq.pop_front() : 'x;
			eb = bq.size() ? bq.pop_front() : 'x;
			`CHK(a_out, ea)
			`CHK(b_out, eb)
		end
	end

	initial begin
		#10000;
		error_cnt++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		repeat (5) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		rd_chk(8'h66, 8'h20);
		rd_chk(8'h67, 8'hC9);
		rd_chk(8'h68, 8'h80);
		rd_chk(8'h69, 8'hC9);
		rd_chk(8'h6A, 8'h80);
		end_test("reset");
		// Unity gain on 1A, mute on 1B, samples back to back
		i_dcog_host_model.wr(8'h69, 8'h00, 1'b0);
		repeat (4) begin
			@(posedge ref_clk_in);
			x = $random(seed);
			vld_in <= 1'b1;
			a_in <= x;
			b_in <= ~x;
			ctx <= 4'($random(seed));
			aq.push_back(x);
			bq.push_back('0);
		end
		@(posedge ref_clk_in);
		vld_in <= 1'b0;
		end_test("gain");
		// Every drive and level code of the negative output byte
		for (int i = 0; i < 8; i++) begin
			d = {i[1:0], i[2:0], i[1], 2'($random(seed))};
			ctx <= 4'($random(seed));
			i_dcog_host_model.wr(8'h66, d, 1'b0);
			rd_chk(8'h66, d);
		end
		// Random readback of the gain bytes
		for (int i = 0; i < 16; i++) begin
			a = 8'h67 + 8'(i % 4);
			d = $random(seed);
			e = a[0] ? d : {d[7:4], 4'h0};
			i_dcog_host_model.wr(a, d, 1'b0);
			rd_chk(a, e);
		end
		// Reserved bits and unmapped places
		i_dcog_host_model.wr(8'h6A, 8'h5F, 1'b1);
		rd_chk(8'h6A, 8'h50);
		i_dcog_host_model.wr(8'h6B, 8'hFF, 1'b0);
		rd_chk(8'h6B, 8'h00);
		rd_chk(8'h65, 8'h00);
		end_test("registers");
		`CHK(rq.size() + aq.size(), 0)
		finish_test();
	end
endmodule
